// [rtl/htrd_defs.svh]
// Constants of the humidity and temperature read-out link.
// Assumes inclusion by bare name from the package and the modules.
`ifndef HTRD_DEFS_SVH
`define HTRD_DEFS_SVH

// Bus address and direction
`define HTRD_ADDR_DEF        7'h78
`define HTRD_RD_BIT          1'b1

// Field positions and widths
`define HTRD_VAL_W           15
`define HTRD_VAL_HI_MSB      14
`define HTRD_VAL_HI_LSB      8
`define HTRD_BITS_PER_BYTE   4'h8
`define HTRD_FIRST_BIT       4'h1
`define HTRD_LAST_BYTE       2'h3
`define HTRD_FIRST_BYTE      2'h0

// Reset values
`define HTRD_CODE_RST        15'h0000
`define HTRD_LINE_IDLE       3'h7

// Buffering
`define HTRD_FIFO_DEPTH      32
`define HTRD_FIFO_MIN_DEPTH  4

`endif

// [rtl/htrd_pkg.sv]
// Types shared by the read-out modules.
// Assumes htrd_defs.svh is on the include path.
`include "htrd_defs.svh"

package htrd_pkg;

  typedef logic [`HTRD_VAL_W-1:0] htrd_code_t;

  // One sample: linear humidity code, linear temperature code
  typedef struct packed {
    htrd_code_t hum;
    htrd_code_t temp;
  } htrd_sample_s;

  // Synchronised link lines
  typedef struct packed {
    logic scl;
    logic sda;
    logic en;
  } htrd_line_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_TX,
    ST_MACK
  } htrd_state_e;

endpackage

// [rtl/htrd_sync.sv]
// Two flip-flop synchroniser for levels.
// Assumes inputs are levels from another clock domain or a pin.
`timescale 1ns/1ps

module htrd_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  if (W < 1) begin : g_bad_w
    $error("htrd_sync: width must be at least one");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= RST;
      q_ff    <= RST;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

// [rtl/htrd_fifo.sv]
// Dual-clock sample FIFO with gray-coded pointers.
// Assumes one asynchronous active-low reset common to both sides.
`timescale 1ns/1ps
`include "htrd_defs.svh"

module htrd_fifo #(
  parameter int W     = 30,
  parameter int DEPTH = `HTRD_FIFO_DEPTH
) (
  input  wire logic         wr_clk,
  input  wire logic         wr_en,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  input  wire logic         rd_clk,
  input  wire logic         rd_ready,
  output logic              rd_valid,
  output logic      [W-1:0] rd_data,
  input  wire logic         rstn
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < `HTRD_FIFO_MIN_DEPTH || (1 << AW) != DEPTH || W < 1) begin : g_bad_depth
    $error("htrd_fifo: depth must be a power of two of at least four");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_ff;
  logic [AW:0]  wgray_ff;
  logic [AW:0]  rbin_ff;
  logic [AW:0]  rgray_ff;
  logic [AW:0]  rgray_w;
  logic [AW:0]  wgray_r;

  wire          push     = wr_en && wr_valid && wr_ready;
  wire          pop      = rd_valid && rd_ready;
  wire [AW:0]   nxt_wbin = wbin_ff + {{AW{1'b0}}, push};
  wire [AW:0]   nxt_rbin = rbin_ff + {{AW{1'b0}}, pop};
  wire [AW:0]   full_cmp = {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};

  // Pointers cross as gray code
  htrd_sync #(.W(AW+1)) u_r2w (
    .clk  (wr_clk),
    .rstn (rstn),
    .d    (rgray_ff),
    .q    (rgray_w)
  );

  htrd_sync #(.W(AW+1)) u_w2r (
    .clk  (rd_clk),
    .rstn (rstn),
    .d    (wgray_ff),
    .q    (wgray_r)
  );

  assign wr_ready = wr_en && (wgray_ff != full_cmp);
  assign rd_valid = (rgray_ff != wgray_r);
  assign rd_data  = mem[rbin_ff[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_ff[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or negedge rstn) begin
    if (!rstn) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
    end else begin
      wbin_ff  <= nxt_wbin;
      wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
    end
  end

  always_ff @(posedge rd_clk or negedge rstn) begin
    if (!rstn) begin
      rbin_ff  <= '0;
      rgray_ff <= '0;
    end else begin
      rbin_ff  <= nxt_rbin;
      rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
    end
  end

endmodule

// [rtl/htrd_readout.sv]
// Humidity and temperature read-out slave on a two-wire link.
// Assumes samples arrive on ref_clk, link logic runs on link_clk
// fast enough to oversample the serial clock, SCL and SDA from pins.
//
// Behaviour
// - The slave takes a 7-bit address and answers only its own, 0x78 by default.
// - On its address with read direction the slave holds SDA low for one SCL high period.
// - After its acknowledge the slave sends two humidity bytes then two temperature bytes.
// - The four-byte sequence repeats for as long as the master acknowledges each byte and sends no stop.
// - A falling SDA while SCL is high is a start and the slave detects it.
// - A rising SDA while SCL is high is a stop and ends the slave's output.
// - Humidity code zero means 0 percent and code 0x7FFF means 100 percent.
// - Temperature code zero means minus 40 C and code 0x7FFF means plus 125 C.
`timescale 1ns/1ps
`include "htrd_defs.svh"

module htrd_readout
  import htrd_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `HTRD_ADDR_DEF,
  parameter int         FIFO_DEPTH = `HTRD_FIFO_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire logic         link_clk,
  input  wire logic         samp_valid,
  input  wire htrd_sample_s samp,
  output logic              samp_ready,
  input  wire logic         scl_pin,
  input  wire logic         sda_pin,
  output logic              sda_drive,
  output logic              sda_oe,
  output logic              link_busy
);

  // Byte of a sample by position in the frame
  function automatic logic [7:0] byte_of(input htrd_sample_s s, input logic [1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      2'h0:    b = {1'b0, s.hum[`HTRD_VAL_HI_MSB:`HTRD_VAL_HI_LSB]};
      2'h1:    b = s.hum[7:0];
      2'h2:    b = {1'b0, s.temp[`HTRD_VAL_HI_MSB:`HTRD_VAL_HI_LSB]};
      default: b = s.temp[7:0];
    endcase
    return b;
  endfunction

  htrd_line_s   line;
  htrd_line_s   prev_ff;
  htrd_state_e  st_ff;
  htrd_state_e  nxt_st;
  logic [3:0]   cnt_ff;
  logic [3:0]   nxt_cnt;
  logic [7:0]   sh_ff;
  logic [7:0]   nxt_sh;
  logic [1:0]   idx_ff;
  logic [1:0]   nxt_idx;
  logic         ack_ff;
  logic         nxt_ack;
  logic         oe_ff;
  logic         nxt_oe;
  htrd_sample_s cur_ff;
  htrd_sample_s nxt_cur;
  logic         busy_ff;
  logic         fifo_rd_valid;
  htrd_sample_s fifo_rd_data;
  logic [2:0]   line_q;
  logic         fetch;
  htrd_sample_s go_cur;

  // Sample buffer, ref_clk side filling, link side draining
  htrd_fifo #(
    .W     ($bits(htrd_sample_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wr_clk   (ref_clk),
    .wr_en    (clk_en),
    .wr_valid (samp_valid),
    .wr_data  (samp),
    .wr_ready (samp_ready),
    .rd_clk   (link_clk),
    .rd_ready (fetch),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .rstn     (rstn)
  );

  // Pins and enable into link domain
  htrd_sync #(.W(3), .RST(`HTRD_LINE_IDLE)) u_pins (
    .clk  (link_clk),
    .rstn (rstn),
    .d    ({scl_pin, sda_pin, clk_en}),
    .q    (line_q)
  );

  assign line = htrd_line_s'(line_q);

  // Line events
  wire en_l      = line.en;
  wire scl_rise  = en_l && line.scl && !prev_ff.scl;
  wire scl_fall  = en_l && !line.scl && prev_ff.scl;
  wire start_det = en_l && line.scl && prev_ff.scl && prev_ff.sda && !line.sda;
  wire stop_det  = en_l && line.scl && prev_ff.scl && !prev_ff.sda && line.sda;

  // Address phase and transmit byte decode
  wire addr_full = (cnt_ff == `HTRD_BITS_PER_BYTE);
  wire addr_hit  = (sh_ff[7:1] == SLAVE_ADDR) && (sh_ff[0] == `HTRD_RD_BIT);
  wire byte_done = (cnt_ff == `HTRD_BITS_PER_BYTE);

  // Sample fetch at frame start and on wrap
  wire ack_end   = (st_ff == ST_ACK) && scl_fall;
  wire wrap      = (st_ff == ST_MACK) && scl_fall && ack_ff && (idx_ff == `HTRD_LAST_BYTE);
  assign fetch   = ack_end || wrap;
  wire [1:0] go_idx = ack_end ? `HTRD_FIRST_BYTE : idx_ff + 2'h1;
  assign go_cur  = (fetch && fifo_rd_valid) ? fifo_rd_data : cur_ff;
  wire [7:0] go_byte = byte_of(go_cur, go_idx);

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh  = sh_ff;
    nxt_idx = idx_ff;
    nxt_ack = ack_ff;
    nxt_oe  = oe_ff;
    nxt_cur = cur_ff;
    if (start_det) begin
      nxt_st  = ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe  = 1'b0;
    end else if (stop_det) begin
      nxt_st  = ST_IDLE;
      nxt_oe  = 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise && !addr_full) begin
            nxt_sh  = {sh_ff[6:0], line.sda};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && addr_full) begin
            nxt_st = addr_hit ? ST_ACK : ST_IDLE;
            nxt_oe = addr_hit;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_st  = ST_TX;
            nxt_sh  = go_byte;
            nxt_idx = go_idx;
            nxt_cur = go_cur;
            nxt_oe  = ~go_byte[7];
            nxt_cnt = `HTRD_FIRST_BIT;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (byte_done) begin
              nxt_st = ST_MACK;
              nxt_oe = 1'b0;
            end else begin
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_oe  = ~sh_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nxt_ack = ~line.sda;
          end else if (scl_fall) begin
            if (ack_ff) begin
              nxt_st  = ST_TX;
              nxt_sh  = go_byte;
              nxt_idx = go_idx;
              nxt_cur = go_cur;
              nxt_oe  = ~go_byte[7];
              nxt_cnt = `HTRD_FIRST_BIT;
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_st = ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Edge history runs freely so a pause does not invent edges
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= htrd_line_s'(`HTRD_LINE_IDLE);
    end else begin
      prev_ff <= line;
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff   <= ST_IDLE;
      cnt_ff  <= 4'h0;
      sh_ff   <= 8'h00;
      idx_ff  <= `HTRD_FIRST_BYTE;
      ack_ff  <= 1'b0;
      oe_ff   <= 1'b0;
      cur_ff  <= {`HTRD_CODE_RST, `HTRD_CODE_RST};
      busy_ff <= 1'b0;
    end else if (en_l) begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      sh_ff   <= nxt_sh;
      idx_ff  <= nxt_idx;
      ack_ff  <= nxt_ack;
      oe_ff   <= nxt_oe;
      cur_ff  <= nxt_cur;
      busy_ff <= (nxt_st != ST_IDLE);
    end
  end

  // Open drain: only ever pulls low
  assign sda_drive = 1'b0;
  assign sda_oe    = oe_ff;
  assign link_busy = busy_ff;

  start_to_addr_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    start_det |=> (st_ff == ST_ADDR) && (cnt_ff == 4'h0) && !oe_ff)
    else $error("start did not open the address phase");

  stop_release_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    stop_det |=> (st_ff == ST_IDLE) && !oe_ff ##1 !oe_ff)
    else $error("stop did not release the data line");

  addr_ack_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_ADDR) && scl_fall && addr_full && !start_det && addr_hit)
      |=> (st_ff == ST_ACK) && oe_ff)
    else $error("matching read address was not acknowledged");

  ack_hold_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_ACK) && scl_rise) |=> oe_ff)
    else $error("acknowledge released during the clock high period");

  addr_miss_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_ADDR) && scl_fall && addr_full && !addr_hit)
      |=> (st_ff == ST_IDLE) && !oe_ff)
    else $error("foreign address or write direction was answered");

  top_bit_zero_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_TX) && (cnt_ff == `HTRD_FIRST_BIT) && !idx_ff[0]) |-> oe_ff)
    else $error("unused top bit of a value was not zero");

  byte_order_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_MACK) && scl_fall && ack_ff && (idx_ff != `HTRD_LAST_BYTE) && en_l)
      |=> (st_ff == ST_TX) && (idx_ff == $past(idx_ff) + 2'h1))
    else $error("bytes left frame order");

  frame_wrap_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    wrap |=> (st_ff == ST_TX) && (idx_ff == `HTRD_FIRST_BYTE))
    else $error("frame did not restart after the last byte");

  nack_end_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_MACK) && scl_fall && !ack_ff) |=> (st_ff == ST_IDLE) ##1 !oe_ff)
    else $error("output continued after a missing acknowledge");

  drive_in_low_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ($changed(oe_ff) && (st_ff != ST_IDLE)) |-> !line.scl || start_det || stop_det)
    else $error("data line changed while the clock was high");

  busy_state_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    link_busy == (st_ff != ST_IDLE))
    else $error("busy flag disagreed with the link state");

  idle_release_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    (st_ff == ST_IDLE) |-> !oe_ff)
    else $error("data line pulled while idle");

  mack_release_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    (st_ff == ST_MACK) |-> !oe_ff)
    else $error("data line pulled during the master acknowledge");

  ack_capture_a : assert property (
    @(posedge link_clk) disable iff (!rstn)
    ((st_ff == ST_MACK) && scl_rise) |=> (ack_ff != $past(line.sda)))
    else $error("master acknowledge was not captured");

endmodule

// [verification/htrd_master_model.sv]
// Two-wire bus master model that reads the humidity and temperature stream.
// Assumes the bench resolves open-drain SDA with a pull-up; SCL idles high.
`timescale 1ns/1ps

module htrd_master_model (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  int stall = 0;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // One SCL pulse, data moves only while SCL is low
  task automatic pulse(input logic b, output logic r);
    #650 sda_m = b;
    #(650 + stall) scl = 1'b1;
    #600 r = sda;
    #600 scl = 1'b0;
  endtask

  // Start or repeated start, SDA falls while SCL high
  task automatic start();
    #650 sda_m = 1'b1;
    #650 scl = 1'b1;
    #600 sda_m = 1'b0;
    #600 scl = 1'b0;
  endtask

  // Stop, SDA rises while SCL high, then bus free time
  task automatic stop();
    #650 sda_m = 1'b0;
    #650 scl = 1'b1;
    #600 sda_m = 1'b1;
    #1300;
  endtask

  // Eight bits MSB first, then the acknowledge pulse
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                      output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(tx[i], r);
      rx[i] = r;
    end
    pulse(ack, ack_seen);
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the humidity and temperature read-out slave.
// Assumes the master model drives SCL and its share of the pulled-up SDA.
`timescale 1ns/1ps
`include "htrd_defs.svh"

module testbench;
  import htrd_pkg::*;

  localparam int DEPTH = 8;

  logic         ref_clk    = 1'b0;
  logic         link_clk   = 1'b0;
  logic         rstn       = 1'b0;
  logic         samp_valid = 1'b0;
  htrd_sample_s samp       = '0;
  logic         samp_ready;
  logic         scl;
  logic         sda_m;
  logic         sda_drive;
  logic         sda_oe;
  logic         link_busy;
  wire          sda = (sda_oe ? sda_drive : 1'b1) & sda_m;
  int           num_errors  = 0;
  int           comparisons = 0;
  htrd_sample_s exp_q[$];
  htrd_sample_s last = '0;

  always #12.5 ref_clk = ~ref_clk;
  always #32 link_clk = ~link_clk;

  htrd_readout #(.FIFO_DEPTH(DEPTH)) dut (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .clk_en     (1'b1),
    .link_clk   (link_clk),
    .samp_valid (samp_valid),
    .samp       (samp),
    .samp_ready (samp_ready),
    .scl_pin    (scl),
    .sda_pin    (sda),
    .sda_drive  (sda_drive),
    .sda_oe     (sda_oe),
    .link_busy  (link_busy)
  );

  htrd_master_model m (
    .scl   (scl),
    .sda_m (sda_m),
    .sda   (sda)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic htrd_sample_s mk(input int k);
    return {15'h4000 + 15'(k), 15'h2A00 + 15'(k)};
  endfunction

  task automatic push(input htrd_sample_s s);
    @(negedge ref_clk);
    samp_valid = 1'b1;
    samp = s;
    for (int n = 0; n < 100 && samp_ready !== 1'b1; n++) @(negedge ref_clk);
    if (samp_ready !== 1'b1) begin
      num_errors++;
      test_done();
    end
    @(negedge ref_clk);
    samp_valid = 1'b0;
    exp_q.push_back(s);
  endtask

  // Read transaction of whole frames, last byte left unacknowledged
  task automatic rd_txn(input int frames);
    logic [7:0] rx;
    logic       a;
    logic [7:0] want[4];
    m.start();
    m.xfer({`HTRD_ADDR_DEF, `HTRD_RD_BIT}, 1'b1, rx, a);
    check(a, 1'b0);
    for (int f = 0; f < frames; f++) begin
      if (exp_q.size() > 0) last = exp_q.pop_front();
      want = '{{1'b0, last.hum[14:8]}, last.hum[7:0], {1'b0, last.temp[14:8]}, last.temp[7:0]};
      for (int b = 0; b < 4; b++) begin
        m.xfer(8'hFF, (f == frames - 1 && b == 3), rx, a);
        check(rx, want[b]);
      end
    end
    m.stop();
    check(sda_oe, 1'b0);
    check(link_busy, 1'b0);
  endtask

  task automatic t_stream();
    rd_txn(1);
    push({15'h7FFF, 15'h0000});
    push({15'h0000, 15'h7FFF});
    m.stall = 2000;
    rd_txn(3);
    m.stall = 0;
    $display("test stream done");
  endtask

  task automatic t_refuse();
    logic [7:0] rx;
    logic       a;
    m.start();
    m.xfer({`HTRD_ADDR_DEF ^ 7'h01, `HTRD_RD_BIT}, 1'b1, rx, a);
    check(a, 1'b1);
    check(link_busy, 1'b0);
    m.start();
    m.xfer({`HTRD_ADDR_DEF, 1'b0}, 1'b1, rx, a);
    check(a, 1'b1);
    m.start();
    for (int i = 0; i < 3; i++) m.pulse(1'b1, a);
    m.stop();
    check(link_busy, 1'b0);
    m.start();
    for (int i = 0; i < 3; i++) m.pulse(1'b1, a);
    rd_txn(1);
    $display("test refuse done");
  endtask

  task automatic t_fill();
    int k;
    @(negedge ref_clk);
    samp_valid = 1'b1;
    for (k = 0; k < 20 && samp_ready === 1'b1; k++) begin
      samp = mk(k);
      exp_q.push_back(samp);
      @(negedge ref_clk);
    end
    check(k, DEPTH);
    samp = mk(99);
    repeat (10) @(negedge ref_clk);
    samp_valid = 1'b0;
    m.stall = 300;
    rd_txn(DEPTH + 1);
    m.stall = 0;
    check(samp_ready, 1'b1);
    $display("test fill done");
  endtask

  initial begin
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_stream();
    t_refuse();
    t_fill();
    test_done();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end
endmodule
